// file: hw/iop_pkg.sv
// Purpose: Shared constants for the eight-bit I/O port with timer sharing
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Printed offsets are odd, so they are indices; byte address is four times
package iop_pkg;
  localparam int unsigned WIDTH = 8;
  localparam logic [15:0] DIR_INDEX = 16'hfeb1;
  localparam logic [15:0] LEVEL_INDEX = 16'hff51;
  localparam logic [15:0] LATCH_INDEX = 16'hff61;
  localparam logic [17:0] DIR_ADDR = {DIR_INDEX, 2'h0};
  localparam logic [17:0] LEVEL_ADDR = {LEVEL_INDEX, 2'h0};
  localparam logic [17:0] LATCH_ADDR = {LATCH_INDEX, 2'h0};
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  // Value returned for the write-only direction register, arbitrary
  localparam logic [7:0] DIR_READ_FILL = 8'h00;
  // Timer field encodings
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [1:0] MODE_PHASE_TOP = 2'h1;
  localparam logic [3:0] MODE_PWM1 = 4'h2;
  localparam logic [3:0] MODE_PWM2 = 4'h3;
  localparam logic [1:0] IO_OFF_LOW = 2'h0;
  localparam logic [1:0] B_CLEAR_SEL = 2'h2;
  localparam logic [1:0] A_CLEAR_SEL = 2'h1;
  localparam int unsigned IO_TOP_BIT = 3;
  localparam int unsigned IO_CMP_HI = 2'h2;
  localparam int unsigned PIN_B = 7;
  localparam int unsigned PIN_A = 6;
  typedef enum logic [1:0] {OWN_GPIO, OWN_TPU, OWN_TMR} iop_owner_t;
endpackage : iop_pkg

// file: hw/iop_pin_sel.sv
// Purpose: Owner selection for one timer-shared pin
// Assumes: Timer fields are stable levels from the timer blocks
// Notes: Used once for each of the two shared pins
`timescale 1ns/1ps
`default_nettype none
module iop_pin_sel (
  // Timer unit settings
  input wire logic [3:0] mode,
  input wire logic [3:0] io_ctrl,
  input wire logic [1:0] clear_sel,
  input wire logic [1:0] pwm2_clear,
  input wire logic pwm1_kill,
  input wire logic pwm1_ok,
  // Eight-bit timer output select
  input wire logic [3:0] tmr_sel,
  // Result
  output iop_pkg::iop_owner_t owner,
  output logic capture_en
);
  // Compare output decode: normal or phase mode with low io bits set
  logic is_capmode;
  logic cmp_out;
  logic pwm1_out;
  logic pwm2_out;
  logic tpu_out;
  assign is_capmode = (mode == iop_pkg::MODE_NORMAL) || (mode[3:2] == iop_pkg::MODE_PHASE_TOP);
  assign cmp_out = is_capmode && !io_ctrl[iop_pkg::IO_TOP_BIT] && (io_ctrl[1:0] != iop_pkg::IO_OFF_LOW);
  assign pwm1_out = pwm1_ok && (mode == iop_pkg::MODE_PWM1) && (io_ctrl[1:0] != iop_pkg::IO_OFF_LOW); // RL14
  // PWM2 only when clear source is not this channel's own compare
  assign pwm2_out = (mode == iop_pkg::MODE_PWM2) && (io_ctrl[1:0] != iop_pkg::IO_OFF_LOW)
    && (clear_sel != pwm2_clear); // RL11
  assign tpu_out = (cmp_out || pwm1_out || pwm2_out) && !pwm1_kill; // RL14
  assign capture_en = is_capmode && io_ctrl[iop_pkg::IO_TOP_BIT]; // RL12
  // Eight-bit timer first, then timer unit, else plain port
  assign owner = (tmr_sel != 4'h0) ? iop_pkg::OWN_TMR :
    (tpu_out ? iop_pkg::OWN_TPU : iop_pkg::OWN_GPIO); // RL13
endmodule : iop_pin_sel
`default_nettype wire

// file: hw/iop_port.sv
// Purpose: Eight-bit I/O port with APB registers and timer pin sharing
// Assumes: One 20 MHz clock, pins synchronous to it
// Notes: Standby inputs model hardware and software standby
// Notes on behaviour
// [RL1] Eight two-way pins; sharing ignores the chip operating mode.
// [RL2] Direction bit 1 makes the pin output, 0 input.
// [RL3] Direction register is write-only; reads return a fill value.
// [RL4] Direction clears on reset and hardware standby, kept in software standby.
// [RL5] Output latch is read/write and drives output pins.
// [RL6] Latch clears on reset and hardware standby, kept in software standby.
// [RL7] Pin-state register is read-only; writes to it are ignored.
// [RL8] Pin-state read gives latch for outputs, pin level for inputs.
// [RL9] Pin-state follows pins after reset, holds during software standby.
// [RL10] Pin 7 owner from channel-5 fields, timer-1 select and direction.
// [RL11] PWM2 drives pin 7 with mode 0011, io not xx00, clear not 10.
// [RL12] Pin 7 feeds capture in mode 0000 or 01xx with top io bit set.
// [RL13] Eight-bit timer output wins, then timer unit, then port.
// [RL14] Pin 6 mirrors with A-side and timer 0; PWM1 disables pin 7 output.
`timescale 1ns/1ps
`default_nettype none
module iop_port (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Standby modes
  input wire logic HW_STANDBY,
  input wire logic SW_STANDBY,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Port pins
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE,
  // Channel 5 timer settings
  input wire logic [3:0] CH5_MODE,
  input wire logic [3:0] CH5_A_IO,
  input wire logic [3:0] CH5_B_IO,
  input wire logic [1:0] CH5_CLEAR_SEL,
  input wire logic CH5_A_OUT,
  input wire logic CH5_B_OUT,
  output logic CH5_A_CAPTURE_IN,
  output logic CH5_B_CAPTURE_IN,
  // Eight-bit timers
  input wire logic [3:0] TMR0_OUT_SEL,
  input wire logic [3:0] TMR1_OUT_SEL,
  input wire logic TMR0_OUT,
  input wire logic TMR1_OUT
);
  logic [7:0] dir_reg;
  logic [7:0] dir_next;
  logic [7:0] latch_reg;
  logic [7:0] latch_next;
  logic [7:0] level_reg;
  logic [7:0] level_next;
  logic [31:0] rdata_next;
  logic [17:0] addr;
  logic sel_dir;
  logic sel_level;
  logic sel_latch;
  logic wr_en;
  logic rd_en;
  logic rd_setup;
  logic [7:0] port_view;
  iop_pkg::iop_owner_t owner_b;
  iop_pkg::iop_owner_t owner_a;
  logic cap_b_en;
  logic cap_a_en;

  // Address decode; printed offsets are word indices
  assign addr = PADDR[17:0];
  assign sel_dir = (addr == iop_pkg::DIR_ADDR) && (PADDR[31:18] == 14'h0000);
  assign sel_level = (addr == iop_pkg::LEVEL_ADDR) && (PADDR[31:18] == 14'h0000);
  assign sel_latch = (addr == iop_pkg::LATCH_ADDR) && (PADDR[31:18] == 14'h0000);
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  // Read data is fetched in the setup cycle so it already stands at the access edge
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  // Zero wait states; unmapped addresses answer with an error
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !(sel_dir || sel_level || sel_latch);

  // Register writes; hardware standby acts as reset, software standby freezes
  assign dir_next = HW_STANDBY ? iop_pkg::DIR_RESET :
    ((wr_en && sel_dir && !SW_STANDBY) ? PWDATA[7:0] : dir_reg); // RL4
  assign latch_next = HW_STANDBY ? iop_pkg::LATCH_RESET :
    ((wr_en && sel_latch && !SW_STANDBY) ? PWDATA[7:0] : latch_reg); // RL5 RL6 RL7

  // Output bits show latch, input bits show pin
  assign port_view = (dir_reg & latch_reg) | (~dir_reg & PIN_IN); // RL2 RL8
  assign level_next = SW_STANDBY ? level_reg : port_view; // RL9

  // Read mux; direction register never reveals its contents
  // Pin-state reads give the frozen copy while software standby holds it
  assign rdata_next = (rd_setup && sel_dir) ? {24'h000000, iop_pkg::DIR_READ_FILL} : // RL3
    (rd_setup && sel_level) ? {24'h000000, (SW_STANDBY ? level_reg : port_view)} : // RL8 RL9
    (rd_setup && sel_latch) ? {24'h000000, latch_reg} : PRDATA; // RL5

  // Registers; PRDATA loads at the setup edge and stands through the access edge
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      dir_reg <= iop_pkg::DIR_RESET; // RL4
      latch_reg <= iop_pkg::LATCH_RESET; // RL6
      level_reg <= 8'h00;
      PRDATA <= 32'h00000000;
    end
    else
    begin
      dir_reg <= dir_next;
      latch_reg <= latch_next;
      level_reg <= level_next;
      PRDATA <= rdata_next;
    end
  end

  // Pin 7 owner; no operating-mode input exists by design
  iop_pin_sel u_sel_b (
    .mode(CH5_MODE),
    .io_ctrl(CH5_B_IO),
    .clear_sel(CH5_CLEAR_SEL),
    .pwm2_clear(iop_pkg::B_CLEAR_SEL),
    .pwm1_kill(CH5_MODE == iop_pkg::MODE_PWM1),
    .pwm1_ok(1'b0),
    .tmr_sel(TMR1_OUT_SEL),
    .owner(owner_b),
    .capture_en(cap_b_en)
  ); // RL1 RL10 RL11 RL14

  // Pin 6 owner, A side with timer 0
  iop_pin_sel u_sel_a (
    .mode(CH5_MODE),
    .io_ctrl(CH5_A_IO),
    .clear_sel(CH5_CLEAR_SEL),
    .pwm2_clear(iop_pkg::A_CLEAR_SEL),
    .pwm1_kill(1'b0),
    .pwm1_ok(1'b1),
    .tmr_sel(TMR0_OUT_SEL),
    .owner(owner_a),
    .capture_en(cap_a_en)
  ); // RL14

  // Pin drive; low pins stay plain port bits
  assign PIN_OUT[5:0] = latch_reg[5:0]; // RL5
  assign PIN_OE[5:0] = dir_reg[5:0]; // RL2
  assign PIN_OUT[iop_pkg::PIN_B] = (owner_b == iop_pkg::OWN_TMR) ? TMR1_OUT :
    ((owner_b == iop_pkg::OWN_TPU) ? CH5_B_OUT : latch_reg[iop_pkg::PIN_B]); // RL13
  assign PIN_OE[iop_pkg::PIN_B] = (owner_b != iop_pkg::OWN_GPIO) || dir_reg[iop_pkg::PIN_B]; // RL10
  assign PIN_OUT[iop_pkg::PIN_A] = (owner_a == iop_pkg::OWN_TMR) ? TMR0_OUT :
    ((owner_a == iop_pkg::OWN_TPU) ? CH5_A_OUT : latch_reg[iop_pkg::PIN_A]); // RL14
  assign PIN_OE[iop_pkg::PIN_A] = (owner_a != iop_pkg::OWN_GPIO) || dir_reg[iop_pkg::PIN_A];
  // Capture inputs see the pin level
  assign CH5_B_CAPTURE_IN = cap_b_en & PIN_IN[iop_pkg::PIN_B]; // RL12
  assign CH5_A_CAPTURE_IN = cap_a_en & PIN_IN[iop_pkg::PIN_A];

  // Checks
  dir_write_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr_en && sel_dir && !SW_STANDBY && !HW_STANDBY |=> dir_reg == $past(PWDATA[7:0])) // RL2
    else $error("direction write lost");
  dir_hide_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    rd_en && sel_dir |-> PRDATA == {24'h000000, iop_pkg::DIR_READ_FILL}) // RL3
    else $error("direction read leaked");
  dir_standby_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    HW_STANDBY |=> dir_reg == iop_pkg::DIR_RESET) // RL4
    else $error("direction not cleared");
  latch_keep_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    SW_STANDBY && !HW_STANDBY |=> $stable(latch_reg) && $stable(dir_reg)) // RL6
    else $error("latch changed in standby");
  latch_read_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    rd_en && sel_latch |-> PRDATA[7:0] == $past(latch_reg)) // RL5
    else $error("latch read wrong");
  level_nowrite_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr_en && sel_level |=> $stable(latch_reg) && $stable(dir_reg)) // RL7
    else $error("pin-state write had effect");
  level_read_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    rd_en && sel_level && !$past(SW_STANDBY)
    |-> PRDATA[7:0] == (($past(dir_reg) & $past(latch_reg)) | (~$past(dir_reg) & $past(PIN_IN)))) // RL8
    else $error("pin-state read wrong");
  level_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    SW_STANDBY |=> level_reg == $past(level_reg)) // RL9
    else $error("pin-state moved in standby");
  tmr_prio_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (TMR1_OUT_SEL != 4'h0) |-> PIN_OE[iop_pkg::PIN_B] && PIN_OUT[iop_pkg::PIN_B] == TMR1_OUT) // RL13
    else $error("timer 1 not on pin 7");
  pwm1_off_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CH5_MODE == iop_pkg::MODE_PWM1) && TMR1_OUT_SEL == 4'h0 |-> PIN_OE[iop_pkg::PIN_B] == dir_reg[iop_pkg::PIN_B]) // RL14
    else $error("pin 7 driven in pwm1");
  pwm2_b_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    TMR1_OUT_SEL == 4'h0 && CH5_MODE == iop_pkg::MODE_PWM2 && CH5_B_IO[1:0] != 2'h0 && CH5_CLEAR_SEL != 2'h2
    |-> PIN_OE[iop_pkg::PIN_B] && PIN_OUT[iop_pkg::PIN_B] == CH5_B_OUT) // RL11
    else $error("pwm2 not on pin 7");
  cap_b_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    CH5_MODE == 4'h0 && CH5_B_IO[3] |-> CH5_B_CAPTURE_IN == PIN_IN[iop_pkg::PIN_B]) // RL12
    else $error("capture path wrong");
endmodule : iop_port
`default_nettype wire

// file: dv/iop_far_model.sv
// Purpose: Board and pin model facing the eight-bit port
// Assumes: An undriven pin follows the board's own weak source
// Notes: A pin that the port drives reads back the port's value
`timescale 1ns/1ps
`default_nettype none
module iop_far_model (
  // Port side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // Board side
  input wire logic [7:0] board_drive,
  output logic [7:0] pin_level
);
  // Port drive wins; the board source stays weak so no contention arises
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & board_drive);
endmodule : iop_far_model
`default_nettype wire

// file: dv/testbench.sv
// Purpose: Self-checking bench for the eight-bit port
// Assumes: Zero-wait APB slave, read data standing at the access edge
// Notes: Timer fields are driven straight from the bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst = 1'b1, hws = 1'b0, sws = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd;
  logic [7:0] bd = 8'h00;
  logic [3:0] mode = 4'h0, aio = 4'h0, bio = 4'h0, s0 = 4'h0, s1 = 4'h0;
  logic [1:0] clr = 2'h0;
  logic ao = 1'b0, bo = 1'b0, t0 = 1'b0, t1 = 1'b0, err;
  wire [31:0] prdata;
  wire pready, pslverr, capa, capb;
  wire [7:0] pin_in, pin_out, pin_oe;
  int num_errors = 0, compares = 0, dir_m, lat_m, i;
  localparam logic [31:0] A_DIR = 32'(iop_pkg::DIR_ADDR);
  localparam logic [31:0] A_LVL = 32'(iop_pkg::LEVEL_ADDR);
  localparam logic [31:0] A_LAT = 32'(iop_pkg::LATCH_ADDR);
  // 20 MHz system clock
  always #25 clk = ~clk;
  iop_port u_dut (.SYS_CLK(clk), .RST(rst), .HW_STANDBY(hws), .SW_STANDBY(sws), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .CH5_MODE(mode), .CH5_A_IO(aio), .CH5_B_IO(bio),
    .CH5_CLEAR_SEL(clr), .CH5_A_OUT(ao), .CH5_B_OUT(bo), .CH5_A_CAPTURE_IN(capa), .CH5_B_CAPTURE_IN(capb),
    .TMR0_OUT_SEL(s0), .TMR1_OUT_SEL(s1), .TMR0_OUT(t0), .TMR1_OUT(t1));
  iop_far_model u_far (.pin_out(pin_out), .pin_oe(pin_oe), .board_drive(bd), .pin_level(pin_in));
  // Verdict in one place
  task automatic end_sim();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
    begin
      num_errors++;
      end_sim();
    end
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  // Pin 7 owner check: expected {oe, out, capture}
  task automatic t7(input logic [3:0] m, input logic [3:0] b, input logic [1:0] c, input logic [3:0] s,
    input logic [2:0] e);
    mode <= m;
    bio <= b;
    clr <= c;
    s1 <= s;
    @(posedge clk);
    #1 chk({29'h0, pin_oe[7], pin_out[7], capb}, {29'h0, e});
    @(posedge clk);
  endtask : t7
  initial
  begin
    void'($urandom(32'h3de3));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bd <= 8'($urandom);
    @(posedge clk);
    apb(1'b0, A_LAT, 32'h0); chk(rd, 32'h0);
    apb(1'b0, A_DIR, 32'h0); chk(rd, 32'(iop_pkg::DIR_READ_FILL));
    apb(1'b1, A_LVL, 32'hff); chk(32'(pin_oe), 32'h0);
    apb(1'b0, A_LVL, 32'h0); chk(rd, 32'(bd));
    apb(1'b0, 32'h4, 32'h0); chk(32'(err), 32'h1);
    $display("test reset done");
    // Random direction, latch and board levels
    for (i = 0; i < 8; i++)
    begin
      dir_m = $urandom & 8'hff;
      lat_m = $urandom & 8'hff;
      bd <= 8'($urandom);
      apb(1'b1, A_DIR, 32'(dir_m));
      apb(1'b1, A_LAT, 32'(lat_m) | 32'hab00);
      apb(1'b0, A_LAT, 32'h0); chk(rd, 32'(lat_m));
      apb(1'b0, A_LVL, 32'h0); chk(rd, 32'((dir_m & lat_m) | (~dir_m & bd)));
      chk(32'(pin_oe), 32'(dir_m));
      chk(32'(pin_out & pin_oe), 32'(dir_m & lat_m));
    end
    $display("test random done");
    // Software standby keeps, hardware standby clears
    sws <= 1'b1;
    apb(1'b1, A_LAT, 32'(~lat_m & 8'hff));
    apb(1'b1, A_DIR, 32'(~dir_m & 8'hff));
    sws <= 1'b0;
    apb(1'b0, A_LAT, 32'h0); chk(rd, 32'(lat_m));
    chk(32'(pin_oe), 32'(dir_m));
    hws <= 1'b1;
    @(posedge clk);
    hws <= 1'b0;
    apb(1'b0, A_LAT, 32'h0); chk(rd, 32'h0);
    chk(32'(pin_oe), 32'h0);
    $display("test standby done");
    // Pin 7 sharing, latch bit 7 high so the port value stands apart
    apb(1'b1, A_DIR, 32'hc0);
    apb(1'b1, A_LAT, 32'h80);
    t7(4'h3, 4'h1, 2'h0, 4'h2, 3'b100);
    t7(4'h3, 4'h1, 2'h0, 4'h0, 3'b100);
    t7(4'h3, 4'h1, 2'h2, 4'h0, 3'b110);
    t7(4'h3, 4'h4, 2'h0, 4'h0, 3'b110);
    t7(4'h0, 4'h8, 2'h0, 4'h0, 3'b111);
    t7(4'h5, 4'h9, 2'h0, 4'h0, 3'b111);
    t7(4'h2, 4'h1, 2'h0, 4'h0, 3'b110);
    s0 <= 4'h1;
    t0 <= 1'b0;
    @(posedge clk);
    #1 chk({30'h0, pin_oe[6], pin_out[6]}, 32'h2);
    $display("test timer done");
    @(posedge clk);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
